// >>> hw/acs_pkg.sv
// shared constants and types for the converter control/status sequencer
package acs_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int WORD_W = 16;
  localparam int CH_W = 3;
  localparam int POS_W = 2;
  localparam int GROUPS_POS = 4;
  localparam int TMR_W = 8;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  // result_reg_a..d: upper byte at even offset, lower byte at odd
  localparam logic [ADDR_W-1:0] OFF_RES_A_HI = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_RES_A_LO = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_RES_B_HI = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_RES_B_LO = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_RES_C_HI = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_RES_C_LO = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_RES_D_HI = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_RES_D_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;

  // ---------------------------------------------------------------
  // converter_control_status fields
  // ---------------------------------------------------------------
  localparam int BIT_DONE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_GO = 5;
  localparam int BIT_SCAN = 4;
  localparam int BIT_SPEED = 3;
  localparam int BIT_SEL_HI = 2;
  localparam int BIT_SEL_LO = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam int RES_PAD_W = WORD_W - RES_W;

  // ---------------------------------------------------------------
  // timing: one state is one clk cycle
  // ---------------------------------------------------------------
  localparam int CYC_PER_STATE = 1;
  localparam int FIRST_SLOW_STATES = 134;
  localparam int FIRST_FAST_STATES = 70;
  localparam int NEXT_SLOW_STATES = 128;
  localparam int NEXT_FAST_STATES = 66;
  localparam logic [TMR_W-1:0] FIRST_SLOW_CYC = TMR_W'(FIRST_SLOW_STATES * CYC_PER_STATE);
  localparam logic [TMR_W-1:0] FIRST_FAST_CYC = TMR_W'(FIRST_FAST_STATES * CYC_PER_STATE);
  localparam logic [TMR_W-1:0] NEXT_SLOW_CYC = TMR_W'(NEXT_SLOW_STATES * CYC_PER_STATE);
  localparam logic [TMR_W-1:0] NEXT_FAST_CYC = TMR_W'(NEXT_FAST_STATES * CYC_PER_STATE);

  typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_t;

endpackage

// >>> hw/acs_result_bank.sv
// four result registers, one per position in a group
`timescale 1ns/1ps
module acs_result_bank (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [acs_pkg::POS_W-1:0] wr_pos,
  input wire logic [acs_pkg::RES_W-1:0] wr_data,
  input wire logic [acs_pkg::POS_W-1:0] rd_pos,
  output logic [acs_pkg::WORD_W-1:0] rd_word
);
  import acs_pkg::*;

  typedef struct packed {
    logic [GROUPS_POS-1:0][RES_W-1:0] res;
  } acs_bank_t;

  acs_bank_t s_q;
  acs_bank_t s_d;

  // low six bits always read as zero
  assign rd_word = {s_q.res[rd_pos], {RES_PAD_W{1'b0}}};

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.res[wr_pos] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> hw/acs_sequencer.sv
// converter control/status register and channel sequencer
// Notes on behaviour
// - single conversion end sets done flag
// - scan sets done flag after whole group
// - flag clears on zero write after read-one
// - done flag with enable raises interrupt
// - writing go one starts conversion
// - single mode clears go at completion
// - scan repeats until go cleared or standby
// - mode bit: single or repeating scan
// - speed bit: 134 or 70 states
// - single mode: select picks inputs 0..7
// - scan: top bit group, low bits count
// - results sixteen bits, low six zero
// - result register by position in group
// - scan restarts at group's first input
// - upper byte read latches lower byte
`timescale 1ns/1ps
module acs_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [acs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [acs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [acs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic standby_req,
  input wire logic [acs_pkg::RES_W-1:0] core_result,
  output logic conv_start,
  output logic [acs_pkg::CH_W-1:0] conv_channel,
  output logic conv_speed_select,
  output logic conv_done_irq
);
  import acs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    acs_state_t st;
    logic conv_done_flag;
    logic done_irq_enable;
    logic conv_go;
    logic scan_mode;
    logic speed;
    logic [CH_W-1:0] input_select;
    logic flag_seen;
    logic [POS_W-1:0] pos;
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] rdata;
    logic start;
    logic [CH_W-1:0] chan;
    logic irq;
  } acs_seq_t;

  acs_seq_t s_q;
  acs_seq_t s_d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic tmr_load;
  logic tmr_abort;
  logic [TMR_W-1:0] tmr_cycles;
  logic tmr_done;
  logic bank_we;
  logic [POS_W-1:0] bank_rd_pos;
  logic [WORD_W-1:0] bank_word;
  logic ctrl_hit;
  logic res_hit;
  logic res_lo;
  logic [DATA_W-1:0] ctrl_byte;
  logic [POS_W-1:0] last_pos;
  logic group_end;

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_byte = CTRL_RESET;
    ctrl_byte[BIT_DONE] = s_q.conv_done_flag;
    ctrl_byte[BIT_IRQ_EN] = s_q.done_irq_enable;
    ctrl_byte[BIT_GO] = s_q.conv_go;
    ctrl_byte[BIT_SCAN] = s_q.scan_mode;
    ctrl_byte[BIT_SPEED] = s_q.speed;
    ctrl_byte[BIT_SEL_HI:BIT_SEL_LO] = s_q.input_select;
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_hit = 1'b0;
    res_hit = 1'b0;
    res_lo = reg_addr[0];
    bank_rd_pos = reg_addr[POS_W:1];
    if (reg_addr == OFF_CTRL) begin
      ctrl_hit = 1'b1;
    end else if (reg_addr <= OFF_RES_D_LO) begin
      res_hit = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // group bookkeeping
  // ---------------------------------------------------------------
  // low select bits give channel count minus one in scan mode
  assign last_pos = s_q.input_select[POS_W-1:0];
  assign group_end = (s_q.pos == last_pos);
  assign bank_we = (s_q.st == ACS_CONV) && tmr_done;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rdata = '0;
    tmr_load = 1'b0;
    tmr_abort = 1'b0;
    tmr_cycles = s_q.speed ? FIRST_FAST_CYC : FIRST_SLOW_CYC;

    // software read side
    if (reg_rd) begin
      if (ctrl_hit) begin
        s_d.rdata = ctrl_byte;
        if (s_q.conv_done_flag) begin
          s_d.flag_seen = 1'b1;
        end
      end else if (res_hit && !res_lo) begin
        s_d.rdata = bank_word[WORD_W-1:DATA_W];
        s_d.temp = bank_word[DATA_W-1:0];
      end else if (res_hit) begin
        s_d.rdata = s_q.temp;
      end
    end

    // software write side; result registers are read-only
    if (reg_wr && ctrl_hit) begin
      s_d.done_irq_enable = reg_wdata[BIT_IRQ_EN];
      s_d.conv_go = reg_wdata[BIT_GO];
      s_d.scan_mode = reg_wdata[BIT_SCAN];
      // changing speed mid-run is the writer's fault; no guard here
      s_d.speed = reg_wdata[BIT_SPEED];
      s_d.input_select = reg_wdata[BIT_SEL_HI:BIT_SEL_LO];
      // a one write, or a zero write without a prior read-one, is ignored
      if (!reg_wdata[BIT_DONE] && s_q.flag_seen) begin
        s_d.conv_done_flag = 1'b0;
      end
      s_d.flag_seen = 1'b0;
    end

    // standby drops go like a software clear
    if (standby_req) begin
      s_d.conv_go = 1'b0;
    end

    case (s_q.st)
      ACS_IDLE: begin
        if (s_d.conv_go) begin
          s_d.st = ACS_CONV;
          s_d.pos = '0;
          s_d.start = 1'b1;
          tmr_load = 1'b1;
          // scan starts at the group's first input
          if (s_d.scan_mode) begin
            s_d.chan = {s_d.input_select[BIT_SEL_HI], {POS_W{1'b0}}};
          end else begin
            s_d.chan = s_d.input_select;
          end
          tmr_cycles = s_d.speed ? FIRST_FAST_CYC : FIRST_SLOW_CYC;
        end
      end
      ACS_CONV: begin
        if (!s_d.conv_go) begin
          // stopped by software or standby: drop the run
          s_d.st = ACS_IDLE;
          tmr_abort = 1'b1;
        end else if (tmr_done) begin
          if (!s_q.scan_mode) begin
            s_d.conv_done_flag = 1'b1;
            s_d.conv_go = 1'b0;
            s_d.st = ACS_IDLE;
          end else begin
            tmr_load = 1'b1;
            s_d.start = 1'b1;
            tmr_cycles = s_q.speed ? NEXT_FAST_CYC : NEXT_SLOW_CYC;
            if (group_end) begin
              s_d.conv_done_flag = 1'b1;
              s_d.pos = '0;
            end else begin
              s_d.pos = s_q.pos + POS_W'(1);
            end
            s_d.chan = {s_q.input_select[BIT_SEL_HI], s_d.pos};
          end
        end
      end
      default: begin
        s_d.st = ACS_IDLE;
      end
    endcase

    // interrupt registered beside the flag, so both change on one edge
    s_d.irq = s_d.conv_done_flag && s_d.done_irq_enable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  acs_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .abort(tmr_abort),
    .cycles(tmr_cycles),
    .done(tmr_done)
  );

  // result lands in the slot of its position in the group
  acs_result_bank u_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(bank_we),
    .wr_pos(s_q.chan[POS_W-1:0]),
    .wr_data(core_result),
    .rd_pos(bank_rd_pos),
    .rd_word(bank_word)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign conv_start = s_q.start;
  assign conv_channel = s_q.chan;
  assign conv_speed_select = s_q.speed;
  assign conv_done_irq = s_q.irq;

endmodule

// >>> hw/acs_timer.sv
// conversion duration down-counter with end pulse
`timescale 1ns/1ps
module acs_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic abort,
  input wire logic [acs_pkg::TMR_W-1:0] cycles,
  output logic done
);
  import acs_pkg::*;

  typedef struct packed {
    logic run;
    logic [TMR_W-1:0] cnt;
  } acs_tmr_t;

  acs_tmr_t s_q;
  acs_tmr_t s_d;

  // done is seen in the last counted cycle, so cycles counts whole conversion
  assign done = s_q.run && (s_q.cnt == TMR_W'(1));

  always_comb begin
    s_d = s_q;
    if (abort) begin
      s_d.run = 1'b0;
    end else if (load) begin
      s_d.run = 1'b1;
      s_d.cnt = cycles;
    end else if (done) begin
      s_d.run = 1'b0;
    end else if (s_q.run) begin
      s_d.cnt = s_q.cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> testbench/acs_sequencer_checker.sv
// port-level assertions for the converter control/status sequencer
`timescale 1ns/1ps
module acs_sequencer_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [acs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [acs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [acs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic standby_req,
  input wire logic [acs_pkg::RES_W-1:0] core_result,
  input wire logic conv_start,
  input wire logic [acs_pkg::CH_W-1:0] conv_channel,
  input wire logic conv_speed_select,
  input wire logic conv_done_irq
);
  import acs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && reg_addr == OFF_CTRL;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // a lone control write, so the speed copy has settled one cycle on
  sequence s_spd_wr;
    ctrl_wr ##1 !ctrl_wr;
  endsequence
  property p_start_pulse;
    conv_start |=> !conv_start [*8];
  endproperty
  property p_speed_copy;
    s_spd_wr |=> conv_speed_select == $past(reg_wdata[BIT_SPEED], 2);
  endproperty
  property p_chan_hold;
    !conv_start |-> $stable(conv_channel);
  endproperty
  property p_irq_fall;
    $fell(conv_done_irq) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
  endproperty
  property p_irq_off;
    ctrl_wr && !reg_wdata[BIT_IRQ_EN] |-> ##2 !conv_done_irq;
  endproperty
  property p_low_zero;
    reg_rd && reg_addr < OFF_CTRL && reg_addr[0] |=> reg_rdata[5:0] == 6'h00;
  endproperty
  property p_standby;
    standby_req |=> !conv_start;
  endproperty
  property p_rd_quiet;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_speed_copy: assert property (p_speed_copy) else $error("speed output wrong");
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  a_low_zero: assert property (p_low_zero) else $error("low bits not zero");
  a_standby: assert property (p_standby) else $error("start in standby");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
endmodule
bind acs_sequencer acs_sequencer_checker i_acs_sequencer_checker (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .standby_req, .core_result, .conv_start, .conv_channel, .conv_speed_select,
  .conv_done_irq);

// >>> testbench/acs_sequencer_tb_top.sv
// self-checking bench for the converter control/status sequencer
`timescale 1ns/1ps
module acs_sequencer_tb_top;
  import acs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic standby_req = 1'b0;
  logic [RES_W-1:0] core_result = 10'h000;
  logic [DATA_W-1:0] reg_rdata;
  logic conv_start;
  logic [CH_W-1:0] conv_channel;
  logic conv_speed_select;
  logic conv_done_irq;
  int n_errors = 0;
  int checked = 0;
  acs_sequencer i_acs_sequencer (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .standby_req, .core_result, .conv_start, .conv_channel, .conv_speed_select, .conv_done_irq);
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for the next start, then compare its channel
  task automatic nxt(input logic [2:0] ch);
    int i;
    i = 0;
    #1;
    while (conv_start !== 1'b1 && i < 200) begin
      tick(1);
      i++;
    end
    chk(8'(conv_start), 8'h01);
    chk(8'(conv_channel), 8'(ch));
    tick(1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals;
    rdc(OFF_CTRL, CTRL_RESET);
    rdc(4'hC, 8'h00);
    wr(OFF_RES_A_HI, 8'hFF);
    rdc(OFF_RES_A_HI, 8'h00);
    rdc(OFF_RES_A_LO, 8'h00);
  endtask
  task automatic t_single_irq;
    core_result <= 10'h2B5;
    wr(OFF_CTRL, 8'h6D);
    #1;
    chk(8'(conv_start), 8'h01);
    chk(8'(conv_channel), 8'h05);
    chk(8'(conv_speed_select), 8'h01);
    tick(69);
    chk(8'(conv_done_irq), 8'h00);
    tick(1);
    chk(8'(conv_done_irq), 8'h01);
    wr(OFF_CTRL, 8'h4D);
    rdc(OFF_CTRL, 8'hCD);
    wr(OFF_CTRL, 8'hCD);
    wr(OFF_CTRL, 8'h4D);
    rdc(OFF_CTRL, 8'hCD);
    wr(OFF_CTRL, 8'h4D);
    tick(2);
    chk(8'(conv_done_irq), 8'h00);
    rdc(OFF_CTRL, 8'h4D);
    rdc(OFF_RES_B_HI, 8'hAD);
    rdc(OFF_RES_B_LO, 8'h40);
  endtask
  task automatic t_channels;
    logic [2:0] ch;
    logic [9:0] r;
    for (int c = 0; c < 8; c++) begin
      ch = 3'(c);
      r = 10'h111 + 10'(ch) * 10'h025;
      core_result <= r;
      wr(OFF_CTRL, 8'h28 | {5'h00, ch});
      tick(1);
      chk(8'(conv_channel), 8'(ch));
      tick(72);
      rdc(OFF_CTRL, 8'h88 | {5'h00, ch});
      rdc({1'b0, ch[1:0], 1'b0}, r[9:2]);
    end
  endtask
  task automatic t_scan;
    int n;
    n = 0;
    core_result <= 10'h155;
    wr(OFF_CTRL, 8'h7E);
    nxt(3'h4);
    nxt(3'h5);
    nxt(3'h6);
    chk(8'(conv_done_irq), 8'h00);
    nxt(3'h4);
    tick(2);
    chk(8'(conv_done_irq), 8'h01);
    nxt(3'h5);
    @(posedge clk);
    standby_req <= 1'b1;
    @(posedge clk);
    standby_req <= 1'b0;
    repeat (150) begin
      tick(1);
      n += int'(conv_start === 1'b1);
    end
    chk(8'(n), 8'h00);
    rdc(OFF_CTRL, 8'hDE);
    rdc(OFF_RES_C_HI, 8'h55);
  endtask
  // slow speed, single then one-channel scan, then a reset in mid-run
  task automatic t_slow;
    core_result <= 10'h0C7;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, 8'h61);
    #1;
    chk(8'(conv_speed_select), 8'h00);
    chk(8'(conv_channel), 8'h01);
    tick(133);
    chk(8'(conv_done_irq), 8'h00);
    tick(1);
    chk(8'(conv_done_irq), 8'h01);
    rdc(OFF_CTRL, 8'hC1);
    rdc(OFF_RES_B_HI, 8'h31);
    rdc(OFF_RES_B_LO, 8'hC0);
    wr(OFF_CTRL, 8'h70);
    #1;
    chk(8'(conv_start), 8'h01);
    chk(8'(conv_channel), 8'h00);
    tick(133);
    chk(8'(conv_start), 8'h00);
    tick(1);
    chk(8'(conv_start), 8'h01);
    tick(127);
    chk(8'(conv_start), 8'h00);
    tick(1);
    chk(8'(conv_start), 8'h01);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(OFF_CTRL, CTRL_RESET);
    rdc(OFF_RES_A_HI, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_single_irq();
    t_channels();
    t_scan();
    t_slow();
    results();
  end
  // whole run needs under 2500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
